// >>> core/capture_pkg.sv
// Constants for the dual capture buffer and sync block.
// Assumes a single 20 MHz core clock and a plain register port.
package capture_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned DEPTH           = 4096;
   localparam int unsigned AW              = 12;
   localparam int unsigned SW              = 16;
   localparam int unsigned RAW             = 10;
   localparam logic [9:0]  OFF_CTRL        = 10'h000;
   localparam logic [9:0]  OFF_STATUS      = 10'h001;
   localparam logic [9:0]  OFF_SRC         = 10'h002;
   localparam logic [9:0]  OFF_DELAY       = 10'h003;
   localparam logic [9:0]  OFF_CAP_DEPTH   = 10'h004;
   localparam logic [9:0]  OFF_THRESH      = 10'h005;
   localparam logic [9:0]  OFF_TRIG_CNT    = 10'h006;
   localparam logic [9:0]  OFF_TIMER       = 10'h007;
   localparam logic [9:0]  OFF_RD_ADDR     = 10'h008;
   localparam logic [9:0]  OFF_RD_I        = 10'h009;
   localparam logic [9:0]  OFF_RD_Q        = 10'h00a;
   localparam logic [9:0]  OFF_PWR_SEL     = 10'h00b;
   localparam logic [9:0]  OFF_PWR_BASE    = 10'h010;
   localparam logic [9:0]  OFF_PEAK_BASE   = 10'h018;
   // Control bit positions
   localparam int unsigned CTRL_ARM0       = 0;
   localparam int unsigned CTRL_ARM1       = 1;
   localparam int unsigned CTRL_SMART0     = 2;
   localparam int unsigned CTRL_SMART1     = 3;
   localparam int unsigned CTRL_PLAY0      = 4;
   localparam int unsigned CTRL_SW_SYNC    = 5;
   localparam int unsigned CTRL_TRIG_SQ    = 6;
   localparam int unsigned CTRL_BUF_SEL    = 7;
   localparam int unsigned CTRL_SYNC_SEL   = 8;
   localparam int unsigned CTRL_TIMER_EN   = 11;
   localparam int unsigned CTRL_PWR_CLR    = 12;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] DELAY_RESET     = 16'h0000;
   localparam logic [12:0] CAP_DEPTH_RESET = 13'h1000;
   localparam logic [15:0] THRESH_RESET    = 16'h7fff;
   localparam logic [15:0] TRIG_CNT_RESET  = 16'h0001;
   localparam logic [15:0] TIMER_RESET     = 16'hffff;
   typedef enum logic [2:0] {SEL_LIMITED, SEL_FEEDBACK, SEL_ERROR, SEL_PROBE,
                             SEL_SOLVER} src_sel_t;
   typedef enum logic [2:0] {SYNC_A, SYNC_B, SYNC_C, SYNC_D, SYNC_TIMER,
                             SYNC_SOFT} sync_sel_t;
endpackage

// >>> core/dual_capture_buffer_sync.sv
// Two 4096-sample capture memories with sync logic, power and peak meters.
// Assumes one 20 MHz clock; sync pins arrive already synchronous to it.
`timescale 1ns/1ps
`default_nettype none
module dual_capture_buffer_sync
   import capture_pkg::*;
(
   input  wire logic          core_clk_in,
   input  wire logic          rst_in,
   input  wire logic          bb_en_in,
   input  wire logic          pd_en_in,
   input  wire logic          sync_a_in,
   input  wire logic          sync_b_in,
   input  wire logic          sync_c_in,
   input  wire logic          differential_sync_pair_in,
   input  wire logic [31:0]   limited_ref_in,
   input  wire logic [31:0]   feedback_path_output_in,
   input  wire logic [31:0]   error_out_in,
   input  wire logic [31:0]   probe_bus_in,
   input  wire logic [31:0]   triangular_solver_error_in,
   input  wire logic [31:0]   baseband_input_router_in,
   input  wire logic [31:0]   crest_in_in,
   input  wire logic [31:0]   crest_out_in,
   input  wire logic [63:0]   predistortion_input_gain_in,
   input  wire logic [31:0]   resampler_output_in,
   input  wire logic [31:0]   nonlinear_out_in,
   input  wire logic [31:0]   linear_out_in,
   input  wire logic [RAW-1:0] addr_in,
   input  wire logic [SW-1:0] wdata_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   output logic      [SW-1:0] rdata_out,
   output logic      [31:0]   playback_out,
   output logic               playback_valid_out,
   output logic               init_done_out,
   output logic               sync_out,
   output logic      [5:0]    sync_fan_out
);
   // Register file
   logic [15:0] ctrl;
   logic [15:0] src_sel;
   logic [15:0] delay_cfg;
   logic [12:0] cap_depth;
   logic [15:0] thresh;
   logic [15:0] trig_cnt;
   logic [15:0] timer_period;
   logic [12:0] rd_addr;
   logic [2:0]  pwr_sel;
   logic [31:0] rd_word;

   wire wr_ctrl = wr_in && addr_in == OFF_CTRL;
   wire sw_sync = wr_ctrl && wdata_in[CTRL_SW_SYNC];
   wire pwr_clr = wr_ctrl && wdata_in[CTRL_PWR_CLR];

   // Sync capture and selection
   logic [2:0]  bb_sync_q;
   logic        pd_sync_q;
   logic [15:0] timer_cnt;
   logic        timer_sync;
   logic        sync_seen;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bb_sync_q <= 3'h0;
      end else if (bb_en_in) begin
         bb_sync_q <= {sync_c_in, sync_b_in, sync_a_in};
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pd_sync_q <= 1'b0;
      end else if (pd_en_in) begin
         pd_sync_q <= differential_sync_pair_in;
      end
   end

   // Pins are held for a whole baseband sample, so qualify with the enable
   wire [5:0] sync_vec = {sw_sync, timer_sync, pd_sync_q && pd_en_in,
                          bb_sync_q & {3{bb_en_in}}};
   wire [2:0] sync_pick = ctrl[CTRL_SYNC_SEL +: 3];
   wire sync_evt = (sync_pick < 3'h6) ? sync_vec[sync_pick] : 1'b0;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         timer_cnt  <= 16'h0000;
         timer_sync <= 1'b0;
      end else begin
         timer_sync <= 1'b0;
         if (!ctrl[CTRL_TIMER_EN]) begin
            timer_cnt <= 16'h0000;
         end else if (timer_cnt >= timer_period) begin
            timer_cnt  <= 16'h0000;
            timer_sync <= 1'b1;
         end else begin
            timer_cnt <= timer_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_seen <= 1'b0;
         sync_out  <= 1'b0;
      end else begin
         if (bb_en_in && bb_sync_q[0]) begin
            sync_seen <= 1'b1;
         end
         sync_out <= sync_evt;
      end
   end
   assign init_done_out = sync_seen;
   // Every sync source is offered to the other consumers in the chip once init is done
   assign sync_fan_out  = sync_vec & {6{sync_seen}};

   // Capture source multiplexers
   wire [31:0] src0 = (src_sel[2:0] == SEL_LIMITED)  ? limited_ref_in :
                      (src_sel[2:0] == SEL_FEEDBACK) ? feedback_path_output_in :
                      (src_sel[2:0] == SEL_ERROR)    ? error_out_in :
                      (src_sel[2:0] == SEL_PROBE)    ? {16'h0000, probe_bus_in[31:16]} :
                      triangular_solver_error_in;
   wire [31:0] src1 = (src_sel[6:4] == SEL_LIMITED)  ? limited_ref_in :
                      (src_sel[6:4] == SEL_FEEDBACK) ? feedback_path_output_in :
                      (src_sel[6:4] == SEL_ERROR)    ? error_out_in :
                      {16'h0000, probe_bus_in[15:0]};

   logic [31:0] cap_word [2];
   logic [1:0]  done;
   logic [31:0] play_word;
   assign cap_word[0] = src0;
   assign cap_word[1] = src1;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : chan
         typedef enum logic [1:0] {IDLE, WAIT_DLY, FILL, DONE} cap_st_t;
         cap_st_t st;
         logic [31:0] mem [DEPTH];
         logic [15:0] dly;
         logic [12:0] cnt;
         logic [15:0] hits;
         logic signed [15:0] si;
         logic signed [15:0] sq;
         logic [15:0] abs_i;
         logic [15:0] abs_q;
         logic [15:0] mag;
         logic [31:0] mag_sq;
         wire smart = ctrl[CTRL_SMART0 + g];
         wire armed = ctrl[CTRL_ARM0 + g];
         wire play  = (g == 0) && ctrl[CTRL_PLAY0];
         assign si = cap_word[g][31:16];
         assign sq = cap_word[g][15:0];
         assign abs_i = si[15] ? 16'(-si) : 16'(si);
         assign abs_q = sq[15] ? 16'(-sq) : 16'(sq);
         // Larger of the two rails stands in for the magnitude
         assign mag = (abs_i > abs_q) ? abs_i : abs_q;
         assign mag_sq = (32'(si) * 32'(si)) + (32'(sq) * 32'(sq));
         // Magnitude rule when CTRL_TRIG_SQ is clear, power rule when set, for both triggers
         wire over = ctrl[CTRL_TRIG_SQ] ? (mag_sq > {thresh, 16'h0000})
                                        : (mag > thresh);
         wire trig = (hits >= trig_cnt);
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               st <= IDLE;
               dly <= 16'h0000;
               cnt <= 13'h0000;
               hits <= 16'h0000;
            end else begin
               case (st)
                  IDLE: begin
                     cnt <= 13'h0000;
                     hits <= 16'h0000;
                     dly <= 16'h0000;
                     if (armed && smart) begin
                        st <= WAIT_DLY;
                     end else if (armed && sync_evt && sync_seen) begin
                        st <= WAIT_DLY;
                     end
                  end
                  WAIT_DLY: begin
                     // Disarming abandons a wait, so no stale capture follows
                     if (!armed) begin
                        st <= IDLE;
                     end else if (smart) begin
                        if (over) begin
                           hits <= hits + 16'h0001;
                        end
                        if (trig) begin
                           st <= FILL;
                        end
                     end else if (dly >= delay_cfg) begin
                        st <= FILL;
                     end else begin
                        dly <= dly + 16'h0001;
                     end
                  end
                  FILL: begin
                     if (!play) begin
                        mem[cnt[AW-1:0]] <= cap_word[g];
                     end
                     cnt <= cnt + 13'h0001;
                     if (cnt + 13'h0001 >= cap_depth) begin
                        st <= DONE;
                     end
                  end
                  DONE: begin
                     if (!armed) begin
                        st <= IDLE;
                     end
                  end
                  default: st <= IDLE;
               endcase
            end
         end
         assign done[g] = (st == DONE);
         wire filling = (st == FILL);
         if (g == 0) begin : pb
            logic [31:0] pbw;
            always_ff @(posedge core_clk_in) begin
               pbw <= mem[cnt[AW-1:0]];
            end
            assign play_word = pbw;
         end
         logic [31:0] rw;
         always_ff @(posedge core_clk_in) begin
            rw <= mem[rd_addr[AW-1:0]];
         end
         if (g == 0) begin : r0
            assign rd_word = ctrl[CTRL_BUF_SEL] ? chan[1].rw : rw;
         end
      end
   endgenerate

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         playback_out       <= 32'h0000_0000;
         playback_valid_out <= 1'b0;
      end else begin
         playback_out       <= ctrl[CTRL_PLAY0] ? play_word : 32'h0000_0000;
         playback_valid_out <= ctrl[CTRL_PLAY0] && chan[0].filling;
      end
   end

   // Power meters load the power at each selected sync until cleared; peak monitors hold the max
   logic [31:0] pwr [3];
   logic [15:0] peak [5];
   wire [31:0] pwr_src [3];
   wire [31:0] peak_src [5];
   assign pwr_src[0] = baseband_input_router_in;
   assign pwr_src[1] = pwr_sel[0] ? crest_out_in : crest_in_in;
   assign pwr_src[2] = pwr_sel[1] ? predistortion_input_gain_in[63:32]
                                  : predistortion_input_gain_in[31:0];
   assign peak_src[0] = resampler_output_in;
   assign peak_src[1] = predistortion_input_gain_in[31:0];
   assign peak_src[2] = nonlinear_out_in;
   assign peak_src[3] = linear_out_in;
   assign peak_src[4] = feedback_path_output_in;

   generate
      for (g = 0; g < 3; g++) begin : pm
         wire signed [15:0] pi = pwr_src[g][31:16];
         wire signed [15:0] pq = pwr_src[g][15:0];
         wire [31:0] p = (32'(pi) * 32'(pi)) + (32'(pq) * 32'(pq));
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               pwr[g] <= 32'h0000_0000;
            end else if (pwr_clr) begin
               pwr[g] <= 32'h0000_0000;
            end else if (sync_evt) begin
               pwr[g] <= p;
            end
         end
      end
      for (g = 0; g < 5; g++) begin : pk
         wire signed [15:0] ki = peak_src[g][31:16];
         wire signed [15:0] kq = peak_src[g][15:0];
         wire [15:0] ai = ki[15] ? 16'(-ki) : 16'(ki);
         wire [15:0] aq = kq[15] ? 16'(-kq) : 16'(kq);
         wire [15:0] m = (ai > aq) ? ai : aq;
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               peak[g] <= 16'h0000;
            end else if (pwr_clr) begin
               peak[g] <= 16'h0000;
            end else if (m > peak[g]) begin
               peak[g] <= m;
            end
         end
      end
   endgenerate

   // Register writes
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl         <= CTRL_RESET;
         src_sel      <= 16'h0000;
         delay_cfg    <= DELAY_RESET;
         cap_depth    <= CAP_DEPTH_RESET;
         thresh       <= THRESH_RESET;
         trig_cnt     <= TRIG_CNT_RESET;
         timer_period <= TIMER_RESET;
         rd_addr      <= 13'h0000;
         pwr_sel      <= 3'h0;
      end else if (wr_in) begin
         case (addr_in)
            OFF_CTRL:      ctrl <= wdata_in & ~16'h1020;
            OFF_SRC:       src_sel <= wdata_in;
            OFF_DELAY:     delay_cfg <= wdata_in;
            OFF_CAP_DEPTH: cap_depth <= (wdata_in[12:0] > 13'h1000 || wdata_in[12:0] == 13'h0000)
                                        ? CAP_DEPTH_RESET : wdata_in[12:0];
            OFF_THRESH:    thresh <= wdata_in;
            OFF_TRIG_CNT:  trig_cnt <= wdata_in;
            OFF_TIMER:     timer_period <= wdata_in;
            OFF_RD_ADDR:   rd_addr <= {1'b0, wdata_in[AW-1:0]};
            OFF_PWR_SEL:   pwr_sel <= wdata_in[2:0];
            default:       ;
         endcase
      end else if (rd_in && addr_in == OFF_RD_Q) begin
         rd_addr <= rd_addr + 13'h0001;
      end
   end

   // Read answer one cycle after the strobe
   logic [RAW-1:0] rd_addr_q;
   logic           rd_q;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_addr_q <= 10'h000;
         rd_q      <= 1'b0;
      end else begin
         rd_addr_q <= addr_in;
         rd_q      <= rd_in;
      end
   end
   wire [2:0] pwr_idx  = rd_addr_q[2:0];
   wire [2:0] peak_idx = rd_addr_q[2:0];
   always_comb begin
      rdata_out = 16'h0000;
      if (rd_q) begin
         case (rd_addr_q)
            OFF_CTRL:      rdata_out = ctrl;
            OFF_STATUS:    rdata_out = {13'h0000, sync_seen, done};
            OFF_SRC:       rdata_out = src_sel;
            OFF_DELAY:     rdata_out = delay_cfg;
            OFF_CAP_DEPTH: rdata_out = {3'h0, cap_depth};
            OFF_THRESH:    rdata_out = thresh;
            OFF_TRIG_CNT:  rdata_out = trig_cnt;
            OFF_TIMER:     rdata_out = timer_period;
            OFF_RD_ADDR:   rdata_out = {3'h0, rd_addr};
            OFF_RD_I:      rdata_out = rd_word[31:16];
            OFF_RD_Q:      rdata_out = rd_word[15:0];
            OFF_PWR_SEL:   rdata_out = {13'h0000, pwr_sel};
            default: begin
               if (rd_addr_q[9:3] == OFF_PWR_BASE[9:3] && pwr_idx < 3'h6)
                  rdata_out = pwr_idx[0] ? pwr[pwr_idx[2:1]][15:0]
                                         : pwr[pwr_idx[2:1]][31:16];
               else if (rd_addr_q[9:3] == OFF_PEAK_BASE[9:3] && peak_idx < 3'h5)
                  rdata_out = peak[peak_idx];
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> testbench/frame_source.sv
// Far-side model: sync pins and complex sample streams.
// Assumes the block takes a sample on every cycle (enables held high).
`timescale 1ns/1ps
`default_nettype none
module frame_source #(
   parameter int FRAME = 600
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   output logic             bb_en_out,
   output logic             pd_en_out,
   output logic [3:0]       sync_out,
   output logic [11:0]      cnt_out,
   output logic [31:0]      pat_out [8]
);
   logic [15:0] fc;
   assign bb_en_out = 1'b1;
   assign pd_en_out = 1'b1;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fc       <= '0;
         cnt_out  <= '0;
         sync_out <= '0;
      end else begin
         fc          <= (fc == 16'(FRAME - 1)) ? 16'h0000 : fc + 16'h0001;
         cnt_out     <= cnt_out + 12'h001;
         sync_out[0] <= (fc == 16'(FRAME - 1));
         sync_out[1] <= (fc % 16'h0064 == 16'h0000);
         sync_out[2] <= (fc % 16'h0082 == 16'h0000);
         sync_out[3] <= (fc % 16'h00aa == 16'h0000);
      end
   end
   // Stream n carries n+1 in the top nibble of I, and Q is the inverse of I
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pat_out[i] = {4'(i + 1), cnt_out, ~{4'(i + 1), cnt_out}};
      end
   end
endmodule
`default_nettype wire

// >>> testbench/capture_assertions.sv
// Checker for the capture block's register port, init and sync outputs.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module capture_checker
   import capture_pkg::*;
(
   input wire logic           core_clk_in,
   input wire logic           rst_in,
   input wire logic           bb_en_in,
   input wire logic           sync_a_in,
   input wire logic [RAW-1:0] addr_in,
   input wire logic [SW-1:0]  wdata_in,
   input wire logic           wr_in,
   input wire logic           rd_in,
   input wire logic [SW-1:0]  rdata_out,
   input wire logic           init_done_out,
   input wire logic           sync_out,
   input wire logic [5:0]     sync_fan_out
);
   logic        seen_a;
   logic [15:0] dly;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         seen_a <= 1'b0;
         dly    <= DELAY_RESET;
      end else begin
         if (sync_a_in && bb_en_in) seen_a <= 1'b1;
         if (wr_in && addr_in == OFF_DELAY) dly <= wdata_in;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   read_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
      else $error("read data not zero outside read");
   unmapped_zero_a: assert property ($past(rd_in) && $past(addr_in) >= 10'h020 |->
      rdata_out == '0) else $error("unmapped read not zero");
   delay_back_a: assert property ($past(rd_in) && $past(addr_in) == OFF_DELAY |->
      rdata_out == dly) else $error("delay read back wrong");
   init_wait_a: assert property (!seen_a |-> !init_done_out)
      else $error("init done before primary sync");
   init_cause_a: assert property ($rose(init_done_out) |->
      $past(sync_a_in) || $past(sync_a_in, 2) || $past(sync_a_in, 3))
      else $error("init done without recent sync");
   init_keep_a: assert property (init_done_out |=> init_done_out)
      else $error("init done dropped");
   fan_gate_a: assert property (sync_fan_out != 6'h00 |-> init_done_out)
      else $error("sync fan out before init");
   sync_pulse_a: assert property (sync_out |=> !sync_out)
      else $error("sync out longer than one cycle");
   status_init_a: assert property ($past(rd_in) && $past(addr_in) == OFF_STATUS |->
      rdata_out[2] == init_done_out) else $error("status init bit wrong");
endmodule
bind dual_capture_buffer_sync capture_checker chk_i (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .bb_en_in(bb_en_in), .sync_a_in(sync_a_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .init_done_out(init_done_out), .sync_out(sync_out),
   .sync_fan_out(sync_fan_out));
`default_nettype wire

// >>> testbench/dual_capture_buffer_sync_bench.sv
// Bench for the capture block: register tasks, captures, syncs, meters.
// Assumes the frame source drives every sync pin and sample stream.
`timescale 1ns/1ps
`default_nettype none
module dual_capture_buffer_sync_bench
   import capture_pkg::*;
;
   localparam logic [9:0]  RA [6] = '{OFF_CTRL, OFF_DELAY, OFF_CAP_DEPTH, OFF_THRESH,
                                      OFF_TRIG_CNT, OFF_TIMER};
   localparam logic [15:0] RV [6] = '{CTRL_RESET, DELAY_RESET, 16'(CAP_DEPTH_RESET),
                                      THRESH_RESET, TRIG_CNT_RESET, TIMER_RESET};
   localparam logic [2:0]  S0 [4] = '{SEL_LIMITED, SEL_FEEDBACK, SEL_ERROR, SEL_SOLVER};
   logic            clk;
   logic            rst;
   logic [RAW-1:0]  addr;
   logic [SW-1:0]   wdata;
   logic            wr;
   logic            rd;
   logic [SW-1:0]   rdata;
   logic [31:0]     pb;
   logic            pb_v;
   logic            init;
   logic            so;
   logic            bb_en;
   logic            pd_en;
   logic [3:0]      sy;
   logic [11:0]     cnt;
   logic [31:0]     pat [8];
   logic [15:0]     v;
   logic [11:0]     o0;
   logic [11:0]     o1;
   logic [11:0]     dd;
   int              n;
   int              err_total;
   int              n_checks;
   frame_source src (.clk_in(clk), .rst_in(rst), .bb_en_out(bb_en), .pd_en_out(pd_en),
      .sync_out(sy), .cnt_out(cnt), .pat_out(pat));
   dual_capture_buffer_sync DUT (.core_clk_in(clk), .rst_in(rst), .bb_en_in(bb_en),
      .pd_en_in(pd_en), .sync_a_in(sy[0]), .sync_b_in(sy[1]), .sync_c_in(sy[2]),
      .differential_sync_pair_in(sy[3]), .limited_ref_in(pat[0]),
      .feedback_path_output_in(pat[1]), .error_out_in(pat[2]), .probe_bus_in(pat[3]),
      .triangular_solver_error_in(pat[4]), .baseband_input_router_in(pat[5]),
      .crest_in_in(pat[6]), .crest_out_in(pat[7]),
      .predistortion_input_gain_in({pat[6], pat[7]}), .resampler_output_in(pat[0]),
      .nonlinear_out_in(pat[1]), .linear_out_in(pat[2]), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .playback_out(pb),
      .playback_valid_out(pb_v), .init_done_out(init), .sync_out(so), .sync_fan_out());
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wreg(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [9:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic count_so(input int lim, output int c);
      c = 0;
      repeat (lim) begin
         @(posedge clk);
         #1 if (so === 1'b1) c++;
      end
   endtask
   // Arm, fire a soft sync, poll done, then read back eight samples
   task automatic capture(input int m, input logic [2:0] s, input logic [15:0] dl,
                          input logic [15:0] ctl, input bit hit, output logic [11:0] ofs);
      logic [15:0] st;
      logic [15:0] vi;
      logic [15:0] vq;
      logic [11:0] pn;
      logic [11:0] at;
      ofs = '0;
      pn  = '0;
      wreg(OFF_SRC, 16'(s) << (4 * m));
      wreg(OFF_DELAY, dl);
      wreg(OFF_CTRL, ctl);
      wreg(OFF_CTRL, ctl | 16'h0020);
      at = cnt;
      st = '0;
      for (int k = 0; k < 300 && st[m] !== 1'b1; k++) rreg(OFF_STATUS, st);
      check(st[m], hit);
      wreg(OFF_CTRL, 16'(m) << 7);
      if (hit) begin
         wreg(OFF_RD_ADDR, 16'h0000);
         repeat (2) @(posedge clk);
         for (int k = 0; k < 8; k++) begin
            rreg(OFF_RD_I, vi);
            rreg(OFF_RD_Q, vq);
            check(vi[15:12], 4'(s) + 4'h1);
            check(vq ^ vi, 16'hffff);
            if (k > 0) check(vi[11:0], pn);
            else ofs = vi[11:0] - at;
            pn = vi[11:0] + 12'h001;
         end
      end
   endtask
   initial begin
      #(50 * 30000);
      err_total++;
      end_sim();
   end
   initial begin
      err_total = 0;
      n_checks  = 0;
      addr      = '0;
      wdata     = '0;
      wr        = 1'b0;
      rd        = 1'b0;
      rst       = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (RA[i]) begin
         rreg(RA[i], v);
         check(v, RV[i]);
      end
      wreg(10'h3ff, 16'h5a5a);
      rreg(10'h3ff, v);
      check(v, 16'h0000);
      check(init, 1'b0);
      count_so(620, n);
      check(n, 1);
      rreg(OFF_STATUS, v);
      check(v[2], 1'b1);
      $display("test reset and init done");
      for (int s = 1; s < 4; s++) begin
         wreg(OFF_CTRL, 16'(s) << 8);
         count_so(180, n);
         check(n != 0, 1);
      end
      wreg(OFF_TIMER, 16'h0031);
      wreg(OFF_CTRL, 16'h0c00);
      count_so(200, n);
      check(n >= 3 && n <= 5, 1);
      $display("test sync selects done");
      wreg(OFF_CAP_DEPTH, 16'h0008);
      foreach (S0[i]) capture(0, S0[i], 16'h0000, 16'h0501, 1, o0);
      for (int s = 0; s < 3; s++) capture(1, 3'(s), 16'h0000, 16'h0502, 1, o0);
      capture(0, SEL_LIMITED, 16'h0000, 16'h0501, 1, o0);
      capture(0, SEL_LIMITED, 16'h0025, 16'h0501, 1, o1);
      dd = o1 - o0;
      check(dd, 12'h025);
      $display("test standard capture done");
      wreg(OFF_TRIG_CNT, 16'h0003);
      for (int t = 0; t < 2; t++) begin
         wreg(OFF_THRESH, 16'h7fff);
         capture(0, SEL_LIMITED, 16'h0000, 16'h0005 | 16'(t << 6), 0, o1);
         wreg(OFF_THRESH, 16'h0100);
         capture(0, SEL_LIMITED, 16'h0000, 16'h0005 | 16'(t << 6), 1, o1);
      end
      $display("test smart capture done");
      wreg(OFF_CTRL, 16'h0511);
      wreg(OFF_CTRL, 16'h0531);
      for (int k = 0; k < 300 && pb_v !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      check(pb_v, 1'b1);
      check(pb[31:28], 4'h1);
      check(pb[31:16] ^ pb[15:0], 16'hffff);
      wreg(OFF_CTRL, 16'h0000);
      $display("test playback done");
      wreg(OFF_PWR_SEL, 16'h0003);
      rreg(OFF_PWR_SEL, v);
      check(v, 16'h0003);
      wreg(OFF_CTRL, 16'h1000);
      repeat (700) @(posedge clk);
      for (int a = 0; a < 3; a++) begin
         rreg(OFF_PWR_BASE + 10'(2 * a), v);
         check(v != 16'h0000, 1);
      end
      for (int a = 0; a < 5; a++) begin
         rreg(OFF_PEAK_BASE + 10'(a), v);
         check(v != 16'h0000, 1);
      end
      $display("test meters done");
      end_sim();
   end
endmodule
`default_nettype wire
